// file: drive_status_pkg.sv
// Purpose: Shared constants for the drive status flag block
// Assumes: 20 MHz clock, 16-bit signed speed and current words
// Notes:   Byte offsets are word aligned on classic Wishbone
package drive_status_pkg;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          DW             = 16;
    // Register byte offsets
    localparam logic [7:0]  FLAGS_OFS      = 8'h00;
    localparam logic [7:0]  CTRL_OFS       = 8'h04;
    localparam logic [7:0]  SPEED_OFS      = 8'h08;
    localparam logic [7:0]  CURRENT_OFS    = 8'h0c;
    localparam logic [7:0]  ANGLE_OFS      = 8'h10;
    // Control field positions and reset
    localparam int          THR_LSB        = 0;
    localparam int          THR_W          = 11;
    localparam int          RELAY_ZS_BIT   = 16;
    localparam int          ENC_SEL_BIT    = 17;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0014;
    // Flag bit positions
    localparam int          FWD_BIT        = 0;
    localparam int          REV_BIT        = 1;
    localparam int          CLIM_BIT       = 2;
    localparam int          BR1_BIT        = 3;
    localparam int          BR2_BIT        = 4;
    localparam int          PHB_BIT        = 5;
    localparam int          ATSPD_BIT      = 6;
    localparam int          OVSPD_BIT      = 7;
    localparam int          ZERO_BIT       = 8;
    localparam int          VCLAMP_BIT     = 9;
    localparam int          PSEQ_BIT       = 10;
    localparam int          OK_BIT         = 11;
    localparam int          ALARM_BIT      = 12;
    localparam int          FIELD_BIT      = 13;
    localparam int          FBLOSS_BIT     = 14;
    localparam int          SUPPLY_BIT     = 15;
    localparam int          PEAK_BIT       = 16;
    localparam int          SOVL_BIT       = 17;
    localparam int          NFLAGS         = 18;
    localparam logic [NFLAGS-1:0] FLAGS_RST = 18'h0_0000;
    // Thresholds
    localparam logic signed [DW-1:0] MAX_SPEED     = 16'sh03e8;
    localparam int                   TOL_PERMILLE  = 15;
    localparam logic [DW-1:0]        AT_SPEED_TOL  =
        DW'((1000 * TOL_PERMILLE) / 1000);
    localparam logic [DW-1:0]        RATED_CURRENT = 16'h03e8;
    localparam logic [DW-1:0]        PEAK_LIMIT    = 16'h07d0;
    localparam logic [DW-1:0]        ANGLE_LIMIT   = 16'h02ff;
    localparam logic [DW-1:0]        OVL_TRIP      = 16'h03e8;
    // Alarm indicator flash half period
    localparam int          FLASH_MS       = 250;
    localparam int          FLASH_CYC      = CLK_HZ / 1000 * FLASH_MS;
endpackage : drive_status_pkg

// file: pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pins
// Assumes: Inputs asynchronous to clk_i
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.q;
endmodule : pin_sync

// file: drive_status_flags.sv
// Purpose: Drive status and diagnostic flags behind a Wishbone slave
// Assumes: Control values come from logic on clk_i; pins are async
// Notes:   Flags refresh on each update_i strobe
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ns
module drive_status_flags
    import drive_status_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [7:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // Control loop values
    input  wire logic                 update_i,
    input  wire logic                 powered_i,
    input  wire logic                 trip_i,
    input  wire logic                 drive_reset_i,
    input  wire logic signed [DW-1:0] speed_fb_i,
    input  wire logic signed [DW-1:0] speed_demand_i,
    input  wire logic signed [DW-1:0] pre_ramp_ref_i,
    input  wire logic signed [DW-1:0] post_ramp_ref_i,
    input  wire logic signed [DW-1:0] current_fb_i,
    input  wire logic [DW-1:0]        firing_angle_i,
    input  wire logic [DW-1:0]        field_current_i,
    input  wire logic [DW-1:0]        overload_acc_i,
    input  wire logic                 overload_rising_i,
    input  wire logic                 clamp_override_i,
    input  wire logic                 clamp_bridge_i,
    input  wire logic                 fire_fwd_i,
    input  wire logic                 fire_rev_i,
    input  wire logic                 phase_back_i,
    input  wire logic                 volt_clamp_i,
    input  wire logic                 feedback_absent_i,
    input  wire logic [2:0]           phase_lost_i,
    // Pins
    input  wire logic                 enc_a_i,
    input  wire logic                 enc_b_i,
    input  wire logic [2:0]           line_phase_i,
    // Indications
    output logic                      zero_led_o,
    output logic                      alarm_led_o,
    output logic                      relay_output_two_o,
    output logic                      status_output_two_o,
    output logic                      status_output_three_o,
    output logic                      fire_suppress_o
);
    typedef struct packed {
        logic [NFLAGS-1:0]  flags;
        logic [31:0]        ctrl;
        logic               enc_fwd;
        logic               enc_a_d;
        logic               l1_d;
        logic               seq_123;
        logic               tripped;
        logic [DW-1:0]      hold_speed;
        logic [DW-1:0]      hold_current;
        logic [DW-1:0]      hold_angle;
        logic [23:0]        flash_cnt;
        logic               flash;
        logic               ack;
        logic [31:0]        rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [1:0] enc_s;
    logic [2:0] line_s;

    function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
        mag = v[DW-1] ? DW'(-v) : v;
    endfunction : mag

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        merge = r;
    endfunction : merge

    pin_sync #(
        .W      (2)
    ) u_enc_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  ({enc_a_i, enc_b_i}),
        .sync_o (enc_s)
    );

    pin_sync #(
        .W      (3)
    ) u_line_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  (line_phase_i),
        .sync_o (line_s)
    );

    logic [DW-1:0]       thr;
    logic [DW-1:0]       spd_mag;
    logic [DW-1:0]       err_mag;
    logic                dir_fwd;
    logic                above_thr;
    logic                peak_now;
    logic signed [DW:0]  err_full;
    logic                wb_req;

    always_comb
    begin
        thr       = DW'(st_r.ctrl[THR_LSB +: THR_W]);
        spd_mag   = mag(speed_fb_i);
        err_full  = {speed_demand_i[DW-1], speed_demand_i}
                  - {speed_fb_i[DW-1], speed_fb_i};
        err_mag   = err_full[DW] ? DW'(-err_full) : err_full[DW-1:0];
        // Encoder quadrature or sign of feedback
        dir_fwd   = st_r.ctrl[ENC_SEL_BIT] ? st_r.enc_fwd
                                           : !speed_fb_i[DW-1];
        above_thr = spd_mag > thr;
        peak_now  = mag(current_fb_i) > PEAK_LIMIT;
        wb_req    = cyc_i && stb_i && !st_r.ack;
    end

    always_comb
    begin
        st_nxt = st_r;

        // Quadrature decode on A edges
        st_nxt.enc_a_d = enc_s[1];
        if (enc_s[1] && !st_r.enc_a_d)
        begin
            st_nxt.enc_fwd = !enc_s[0];
        end
        else if (!enc_s[1] && st_r.enc_a_d)
        begin
            st_nxt.enc_fwd = enc_s[0];
        end

        // Sequence sampled at L1 rising edge
        st_nxt.l1_d = line_s[0];
        if (line_s[0] && !st_r.l1_d)
        begin
            st_nxt.seq_123 = !line_s[1];
        end

        // Trip latch: a new trip wins over the reset
        if (trip_i || peak_now)
        begin
            st_nxt.tripped = 1'b1;
        end
        else if (drive_reset_i)
        begin
            st_nxt.tripped = 1'b0;
        end

        // Readbacks still take the values present at the trip edge
        if (!st_r.tripped)
        begin
            st_nxt.hold_speed   = speed_fb_i;
            st_nxt.hold_current = current_fb_i;
            st_nxt.hold_angle   = firing_angle_i;
        end

        if (update_i)
        begin
            st_nxt.flags[FWD_BIT]    = dir_fwd && above_thr;
            st_nxt.flags[REV_BIT]    = !dir_fwd && above_thr;
            st_nxt.flags[ZERO_BIT]   = !above_thr;
            st_nxt.flags[CLIM_BIT]   = clamp_override_i
                                     || clamp_bridge_i;
            st_nxt.flags[BR1_BIT]    = fire_fwd_i;
            st_nxt.flags[BR2_BIT]    = fire_rev_i;
            st_nxt.flags[PHB_BIT]    = phase_back_i;
            st_nxt.flags[ATSPD_BIT]  = (post_ramp_ref_i == pre_ramp_ref_i)
                                     && (err_mag < AT_SPEED_TOL);
            st_nxt.flags[OVSPD_BIT]  = speed_fb_i > MAX_SPEED;
            st_nxt.flags[VCLAMP_BIT] = volt_clamp_i;
            st_nxt.flags[PSEQ_BIT]   = st_r.seq_123;
            st_nxt.flags[OK_BIT]     = powered_i
                                     && !st_nxt.tripped;
            st_nxt.flags[SOVL_BIT]   = overload_acc_i >= OVL_TRIP;
            st_nxt.flags[ALARM_BIT]  = overload_rising_i
                                     && !st_nxt.flags[SOVL_BIT];
            st_nxt.flags[FIELD_BIT]  = field_current_i == '0;
            st_nxt.flags[FBLOSS_BIT] = feedback_absent_i
                                     && firing_angle_i > ANGLE_LIMIT;
            st_nxt.flags[SUPPLY_BIT] = |phase_lost_i;
            st_nxt.flags[PEAK_BIT]   = peak_now;
        end
        else if (peak_now)
        begin
            st_nxt.flags[PEAK_BIT]   = 1'b1;
        end

        // Alarm indicator flash
        if (st_r.flags[ALARM_BIT])
        begin
            if (st_r.flash_cnt >= 24'(FLASH_CYCLES - 1))
            begin
                st_nxt.flash_cnt = '0;
                st_nxt.flash     = !st_r.flash;
            end
            else
            begin
                st_nxt.flash_cnt = st_r.flash_cnt + 24'h00_0001;
            end
        end
        else
        begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash     = 1'b0;
        end

        // Wishbone: answer one cycle after request
        st_nxt.ack   = wb_req;
        st_nxt.rdata = '0;
        if (wb_req)
        begin
            if (we_i && adr_i == CTRL_OFS)
            begin
                st_nxt.ctrl = merge(st_r.ctrl, dat_i, sel_i);
            end
            if (!we_i)
            begin
                case (adr_i)
                    FLAGS_OFS:   st_nxt.rdata = 32'(st_r.flags);
                    CTRL_OFS:    st_nxt.rdata = st_r.ctrl;
                    SPEED_OFS:   st_nxt.rdata = 32'(st_r.hold_speed);
                    CURRENT_OFS: st_nxt.rdata = 32'(st_r.hold_current);
                    ANGLE_OFS:   st_nxt.rdata = 32'(st_r.hold_angle);
                    default:     st_nxt.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r       <= '0;
            st_r.ctrl  <= CTRL_RST;
            st_r.flags <= FLAGS_RST;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign dat_o                 = st_r.rdata;
    assign ack_o                 = st_r.ack;
    assign zero_led_o            = st_r.flags[ZERO_BIT];
    assign relay_output_two_o    = st_r.flags[ZERO_BIT]
                                 && st_r.ctrl[RELAY_ZS_BIT];
    assign alarm_led_o           = st_r.flash;
    assign status_output_two_o   = st_r.flags[ATSPD_BIT];
    assign status_output_three_o = st_r.flags[ALARM_BIT];
    assign fire_suppress_o       = peak_now
                                 || st_r.flags[PEAK_BIT];
endmodule : drive_status_flags

// file: drive_status_flags_assertions.sv
// Purpose: Port checks for the drive status flag block
// Assumes: One clock; bench holds ce_i high
// Notes:   Bound at the foot of this file
`timescale 1ns/1ns
module drive_status_flags_chk
    import drive_status_pkg::*;
#(
    parameter int FLASH_CYCLES = 4
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire logic                 cyc_i,
    input wire logic                 stb_i,
    input wire logic                 update_i,
    input wire logic                 overload_rising_i,
    input wire logic signed [DW-1:0] speed_fb_i,
    input wire logic signed [DW-1:0] pre_ramp_ref_i,
    input wire logic signed [DW-1:0] post_ramp_ref_i,
    input wire logic signed [DW-1:0] current_fb_i,
    input wire logic [DW-1:0]        overload_acc_i,
    input wire logic [31:0]          dat_o,
    input wire logic                 ack_o,
    input wire logic                 zero_led_o,
    input wire logic                 alarm_led_o,
    input wire logic                 status_output_two_o,
    input wire logic                 status_output_three_o,
    input wire logic                 fire_suppress_o
);
    localparam int FL = 2 * FLASH_CYCLES + 2;
    wire upd = update_i && ce_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_next: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("no ack one cycle after request");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data without ack");
    a_peak_cut: assert property
        (current_fb_i > 16'sd2000 |-> fire_suppress_o)
        else $error("firing not suppressed on peak");
    a_zero_on: assert property
        (upd && speed_fb_i == 16'sh0 |=> zero_led_o)
        else $error("zero speed led off at standstill");
    a_zero_off: assert property
        (upd && speed_fb_i > 16'sh07ff |=> !zero_led_o)
        else $error("zero speed led on at speed");
    a_alarm_set: assert property
        (upd && overload_rising_i && overload_acc_i < 16'h03e8
            |=> status_output_three_o)
        else $error("alarm output missing");
    a_sust_alarm: assert property
        (upd && overload_acc_i >= 16'h03e8 |=> !status_output_three_o)
        else $error("alarm output during trip level");
    a_ramp_differs: assert property
        (upd && pre_ramp_ref_i != post_ramp_ref_i
            |=> !status_output_two_o)
        else $error("at speed while ramping");
    a_alarm_flash: assert property
        ($rose(status_output_three_o) |-> ##[1:FL] alarm_led_o)
        else $error("alarm led does not flash");
    c_alarm: cover property (status_output_three_o);
    c_peak: cover property (fire_suppress_o);
    c_zero: cover property ($fell(zero_led_o));
endmodule : drive_status_flags_chk

bind drive_status_flags drive_status_flags_chk #(
    .FLASH_CYCLES(FLASH_CYCLES)
) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .update_i(update_i), .overload_rising_i(overload_rising_i),
    .speed_fb_i(speed_fb_i), .pre_ramp_ref_i(pre_ramp_ref_i),
    .post_ramp_ref_i(post_ramp_ref_i), .current_fb_i(current_fb_i),
    .overload_acc_i(overload_acc_i), .dat_o(dat_o), .ack_o(ack_o),
    .zero_led_o(zero_led_o), .alarm_led_o(alarm_led_o),
    .status_output_two_o(status_output_two_o),
    .status_output_three_o(status_output_three_o),
    .fire_suppress_o(fire_suppress_o));

// file: drive_pins_model.sv
// Purpose: Encoder and mains phase pins seen by the drive
// Assumes: One step every 32 clocks, slow against the pin filters
// Notes:   Bench picks direction and phase order
`timescale 1ns/1ns
module drive_pins_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       rev_i,
    input  wire logic       swap_i,
    output logic            enc_a_o,
    output logic            enc_b_o,
    output logic [2:0]      line_o
);
    logic [4:0] div_r;
    logic [1:0] q_r;
    logic [2:0] s_r;
    logic [1:0] g;
    logic       l2;
    logic       l3;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_r <= 5'h0;
            q_r   <= 2'h0;
            s_r   <= 3'h0;
        end
        else
        begin
            div_r <= div_r + 5'h1;
            if (div_r == 5'h1f)
            begin
                q_r <= q_r + 2'h1;
                s_r <= (s_r == 3'h5) ? 3'h0 : s_r + 3'h1;
            end
        end
    end
    assign g       = {q_r[1], q_r[1] ^ q_r[0]};
    assign enc_a_o = rev_i ? g[1] : g[0];
    assign enc_b_o = rev_i ? g[0] : g[1];
    assign l2      = s_r >= 3'h2 && s_r < 3'h5;
    assign l3      = s_r >= 3'h4 || s_r == 3'h0;
    assign line_o  = {swap_i ? l2 : l3, swap_i ? l3 : l2, s_r < 3'h3};
endmodule : drive_pins_model

// file: tb_top.sv
// Purpose: Self-checking bench for the drive status flag block
// Assumes: Flags read back over the register bus
// Notes:   Alarm flash shortened to 4 cycles
`timescale 1ns/1ns
module tb_top
    import drive_status_pkg::*;
;
    logic clk_i, rst_i = 1, cyc = 0, stb = 0, we = 0, upd = 0, pwr = 1;
    logic trip = 0, dres = 0, orise = 0, fba = 0, rev = 0, swp = 0;
    logic ack_o, zled, aled, rly, so2, so3, fsup, ea, eb;
    logic [6:0] lv = 7'h0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic signed [DW-1:0] spd = 0, dem = 0, pre = 0, cur = 0, post = 0;
    logic [DW-1:0] ang = 16'h0, fld = 16'h0064, acc = 16'h0;
    logic [2:0] lph;
    int n_mismatch = 0, checks_done = 0, cyc_cnt = 0;
    localparam logic [31:0] C = 32'h0c00, B0 = 32'h0d40;

    drive_status_flags #(.FLASH_CYCLES(4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .update_i(upd), .powered_i(pwr), .trip_i(trip),
        .drive_reset_i(dres), .speed_fb_i(spd), .speed_demand_i(dem),
        .pre_ramp_ref_i(pre), .post_ramp_ref_i(post), .current_fb_i(cur),
        .firing_angle_i(ang), .field_current_i(fld), .overload_acc_i(acc),
        .overload_rising_i(orise), .clamp_override_i(lv[5]),
        .clamp_bridge_i(lv[6]), .fire_fwd_i(lv[4]), .fire_rev_i(lv[3]),
        .phase_back_i(lv[2]), .volt_clamp_i(lv[1]), .feedback_absent_i(fba),
        .phase_lost_i({1'b0, lv[0], 1'b0}), .enc_a_i(ea), .enc_b_i(eb),
        .line_phase_i(lph), .zero_led_o(zled), .alarm_led_o(aled),
        .relay_output_two_o(rly), .status_output_two_o(so2),
        .status_output_three_o(so3), .fire_suppress_o(fsup));

    drive_pins_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .rev_i(rev),
        .swap_i(swp), .enc_a_o(ea), .enc_b_o(eb), .line_o(lph));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; waits for ack, read data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack_o !== 1'b1);
        rdat = dat_o;
        // Ack is due one edge after the request is taken
        chk(32'(k), 32'h2);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic fl(input logic [31:0] exp);
        @(posedge clk_i);
        upd <= 1'b1;
        @(posedge clk_i);
        upd <= 1'b0;
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk(rdat, exp);
    endtask : fl

    task automatic sp(input logic signed [DW-1:0] s, d, p,
                      input logic [31:0] exp);
        spd <= s;
        dem <= d;
        pre <= p;
        fl(exp);
    endtask : sp

    task automatic s_regs;
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rdat, CTRL_RST);
        wb(1'b1, FLAGS_OFS, 32'hffff_ffff);
        wb(1'b0, 8'h3c, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk(rdat, 32'h0);
    endtask : s_regs

    task automatic s_dir;
        sp(0, 0, 0, B0);
        sp(20, 20, 0, B0);
        sp(21, 0, 0, C | 32'h1);
        sp(-21, 0, 0, C | 32'h2);
        wb(1'b1, CTRL_OFS, 32'h0001_0014);
        sp(0, 0, 0, B0);
        chk({zled, rly}, 32'h3);
        sp(500, 0, 0, C | 32'h1);
        chk({zled, rly}, 32'h0);
    endtask : s_dir

    task automatic s_levels;
        int tab[7] = '{CLIM_BIT, CLIM_BIT, BR1_BIT, BR2_BIT, PHB_BIT,
                       VCLAMP_BIT, SUPPLY_BIT};
        spd <= 0;
        for (int i = 0; i < 7; i++)
        begin
            lv <= 7'h40 >> i;
            fl(B0 | (32'h1 << tab[i]));
        end
        lv <= 7'h0;
    endtask : s_levels

    task automatic s_speed;
        sp(500, 500, 0, C | 32'h41);
        sp(514, 500, 0, C | 32'h41);
        sp(515, 500, 0, C | 32'h1);
        sp(500, 500, 100, C | 32'h1);
        post <= 100;
        sp(500, 500, 100, C | 32'h41);
        chk({31'h0, so2}, 32'h1);
        post <= 0;
        sp(1000, 1000, 0, C | 32'h41);
        sp(1001, 1001, 0, C | 32'hc1);
        sp(16'sh1000, 16'sh1000, 0, C | 32'hc1);
        sp(0, 0, 0, B0);
    endtask : s_speed

    task automatic s_fault;
        fld <= 16'h0;
        fl(B0 | 32'h2000);
        fld <= 16'h0064;
        fba <= 1'b1;
        ang <= 16'h02ff;
        fl(B0);
        ang <= 16'h0300;
        fl(B0 | 32'h4000);
        fba <= 1'b0;
        orise <= 1'b1;
        acc <= 16'h03e7;
        fl(B0 | 32'h1000);
        repeat (2) @(posedge clk_i);
        chk({30'h0, so3, aled}, 32'h3);
        acc <= 16'h03e8;
        fl(B0 | 32'h2_0000);
        orise <= 1'b0;
        acc <= 16'h0;
        pwr <= 1'b0;
        fl(B0 & ~32'h800);
        pwr <= 1'b1;
        spd <= 300;
        trip <= 1'b1;
        @(posedge clk_i);
        trip <= 1'b0;
        spd <= 400;
        ang <= 16'h0100;
        fl(32'h401);
        wb(1'b0, SPEED_OFS, 32'h0);
        chk({16'h0, rdat[15:0]}, 32'h012c);
        wb(1'b0, ANGLE_OFS, 32'h0);
        chk(rdat, 32'h0300);
        dres <= 1'b1;
        @(posedge clk_i);
        dres <= 1'b0;
        wb(1'b0, SPEED_OFS, 32'h0);
        chk({16'h0, rdat[15:0]}, 32'h0190);
        wb(1'b0, ANGLE_OFS, 32'h0);
        chk(rdat, 32'h0100);
        spd <= 0;
        cur <= 2000;
        @(posedge clk_i);
        chk({31'h0, fsup}, 32'h0);
        cur <= 2001;
        @(posedge clk_i);
        chk({31'h0, fsup}, 32'h1);
        fl(32'h1_0540);
        cur <= 16'sh0005;
        wb(1'b0, CURRENT_OFS, 32'h0);
        chk({16'h0, rdat[15:0]}, 32'h07d1);
        cur <= 0;
        dres <= 1'b1;
        @(posedge clk_i);
        dres <= 1'b0;
        fl(B0);
    endtask : s_fault

    task automatic s_enc;
        wb(1'b1, CTRL_OFS, 32'h0002_0014);
        spd <= 500;
        repeat (300) @(posedge clk_i);
        fl(C | 32'h1);
        rev <= 1'b1;
        repeat (300) @(posedge clk_i);
        fl(C | 32'h2);
        swp <= 1'b1;
        repeat (400) @(posedge clk_i);
        fl(32'h802);
    endtask : s_enc

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_dir();
        s_levels();
        s_speed();
        s_fault();
        s_enc();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk(rdat, 32'h0);
        report_and_stop();
    end
endmodule : tb_top
